// >>> core/kes_pkg.sv
// Package: register map, field positions and carrier types for keyboard emulation status
package kes_pkg;

  // ****************************************************************
  // Register map, memory-mapped operational space
  // ****************************************************************
  localparam logic [11:0] KES_CONTROL_OFS = 12'h100;
  localparam logic [11:0] KES_INBYTE_OFS = 12'h104;
  localparam logic [11:0] KES_OUTBYTE_OFS = 12'h108;
  localparam logic [11:0] KES_STATUS_OFS = 12'h10C;

  // Legacy I/O ports
  localparam logic [7:0] KES_DATA_PORT = 8'h60;
  localparam logic [7:0] KES_CMD_PORT = 8'h64;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int KES_ST_OUT_FULL = 0;
  localparam int KES_ST_IN_FULL = 1;
  localparam int KES_ST_FLAG = 2;
  localparam int KES_ST_CMD_DATA = 3;
  localparam int KES_ST_INHIBIT = 4;
  localparam int KES_ST_AUX_FULL = 5;
  localparam int KES_ST_TIMEOUT = 6;
  localparam int KES_ST_PARITY = 7;

  // Control field positions
  localparam int KES_CT_EMU_EN = 0;
  localparam int KES_CT_EMU_IRQ = 1;
  localparam int KES_CT_CHAR_PEND = 2;
  localparam int KES_CT_IRQ_EN = 3;

  // Control bit 1 is a live view, never stored
  localparam logic [3:0] KES_CTRL_WMASK = 4'hD;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] KES_STATUS_RST = 8'h00;
  localparam logic [3:0] KES_CONTROL_RST = 4'h0;
  localparam logic [7:0] KES_BYTE_RST = 8'h00;
  localparam logic [31:0] KES_WORD_RST = 32'h00000000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } kes_mem_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] port;
    logic [7:0] wdata;
  } kes_io_req_t;

endpackage

// >>> core/kes_sync.sv
// Module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module kes_sync (
  input wire logic clk_in, // 40 MHz register clock
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic ce_in, // Clock enable, freezes state when low
  input wire logic async_in, // Pin from outside the clock domain
  output logic level_out, // Filtered level
  output logic change_out // One-cycle pulse when level_out changes
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
    logic chg;
  } kes_sync_state_t;

  kes_sync_state_t st;
  kes_sync_state_t next_st;

  // A change only counts once stages two and three agree; stage one feeds stage two only
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.chg = (st.s2 == st.s3) && (st.s3 != st.val);
    if (st.s2 == st.s3) begin
      next_st.val = st.s3;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign level_out = st.val;
  assign change_out = st.chg;

endmodule // kes_sync

`default_nettype wire

// >>> core/kes_core.sv
// Module: legacy keyboard controller emulation status, control and data registers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] Emulation on: reading command port returns the status register.
// [R2] Memory-mapped reads and writes only store values, no flag side effects.
// [R3] Data port write clears command/data bit; command port write sets it.
// [R4] Port write sets input-full unless part of a gate A20 sequence.
// [R5] Input-full high with emulation enabled holds an emulation interrupt.
// [R6] Data port read clears output-full.
// [R7] Output-full low with character pending holds an emulation interrupt.
// [R8] Aux line asserts when aux-full, output-full and IRQ enable all set.
// [R9] With IRQ enable, aux-full selects which line reports output-full.
// [R10] Bit 7 reports parity error, bit 6 reports time-out.
// [R11] Bit 4 follows keyboard inhibit switch; set means keyboard active.
// [R12] Bit 2 is a software flag; hardware ignores it.
// [R13] Software writes reserved upper status bits as zero.
// [R14] Emulation enable gates port decode and legacy interrupt lines.
// [R15] Output-full: keyboard line if aux-full low, aux line otherwise.
// [R16] Port writes with emulation on capture the byte into the input register.
// [R17] Data port read with emulation on returns the output register.
// [R18] Both interrupt conditions merge into one output, gated by enable.
// [R19] Flags reset to zero and take direct software writes.
module kes_core (
  input wire logic clk_in, // 40 MHz register clock
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic ce_in, // Clock enable, freezes all state when low
  input wire kes_pkg::kes_mem_req_t mem_req_in, // Operational register access
  output logic [31:0] mem_rdata_out, // Register read data, one cycle after rd
  input wire kes_pkg::kes_io_req_t io_req_in, // Legacy port access
  output logic [7:0] io_rdata_out, // Port read data, one cycle after rd
  output logic io_claim_out, // Port access decoded this cycle
  input wire logic a20_seq_in, // Current port write belongs to a gate A20 sequence
  input wire logic parity_err_in, // Parity error pulse from keyboard logic
  input wire logic timeout_in, // Time-out pulse from keyboard logic
  input wire logic inhibit_sw_in, // Keyboard inhibit switch pin
  output logic emu_irq_out, // Emulation interrupt to emulation software
  output logic keyboard_irq_line_out, // Legacy keyboard interrupt line
  output logic aux_device_irq_line_out // Legacy auxiliary device interrupt line
);

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] control;
    logic [7:0] inbyte;
    logic [7:0] outbyte;
    logic [7:0] io_rdata;
    logic [31:0] mem_rdata;
  } kes_core_state_t;

  kes_core_state_t st;
  kes_core_state_t next_st;

  logic inhibit_level;
  logic inhibit_change;
  logic emulation_enable;
  logic legacy_irq_enable;
  logic io_hit;
  logic io_data_port;
  logic io_cmd_port;
  logic emu_irq;

  // ****************************************************************
  // Inhibit switch synchroniser
  // ****************************************************************
  kes_sync u_inhibit_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .async_in(inhibit_sw_in),
    .level_out(inhibit_level),
    .change_out(inhibit_change)
  );

  // ****************************************************************
  // Decode and interrupt conditions
  // ****************************************************************
  // Ports are only claimed while emulation is on
  assign emulation_enable = st.control[kes_pkg::KES_CT_EMU_EN];
  assign legacy_irq_enable = st.control[kes_pkg::KES_CT_IRQ_EN];
  assign io_data_port = (io_req_in.port == kes_pkg::KES_DATA_PORT);
  assign io_cmd_port = (io_req_in.port == kes_pkg::KES_CMD_PORT);
  assign io_hit = emulation_enable && (io_data_port || io_cmd_port); // R14
  assign io_claim_out = io_hit && (io_req_in.rd || io_req_in.wr);

  // Either condition raises the single emulation interrupt
  assign emu_irq = emulation_enable &&
    (st.status[kes_pkg::KES_ST_IN_FULL] || // R5
    (!st.status[kes_pkg::KES_ST_OUT_FULL] && st.control[kes_pkg::KES_CT_CHAR_PEND])); // R7
  assign emu_irq_out = emu_irq; // R18

  // Aux-full steers output-full onto one of the two legacy lines
  assign keyboard_irq_line_out = emulation_enable && legacy_irq_enable &&
    st.status[kes_pkg::KES_ST_OUT_FULL] && !st.status[kes_pkg::KES_ST_AUX_FULL]; // R15
  assign aux_device_irq_line_out = emulation_enable && legacy_irq_enable &&
    st.status[kes_pkg::KES_ST_OUT_FULL] && st.status[kes_pkg::KES_ST_AUX_FULL]; // R8 R9

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Order: port read clear, then software write, then hardware sets, so no set is lost
  always_comb begin
    next_st = st;
    // Port read path
    if (io_hit && io_req_in.rd) begin
      if (io_data_port) begin
        next_st.io_rdata = st.outbyte; // R17
        next_st.status[kes_pkg::KES_ST_OUT_FULL] = 1'b0; // R6
      end else begin
        next_st.io_rdata = st.status; // R1
      end
    end
    // Memory-mapped path stores only, reads have no effect on flags
    if (mem_req_in.wr) begin
      if (mem_req_in.addr == kes_pkg::KES_CONTROL_OFS) begin
        next_st.control = mem_req_in.wdata[3:0] & kes_pkg::KES_CTRL_WMASK;
      end else if (mem_req_in.addr == kes_pkg::KES_INBYTE_OFS) begin
        next_st.inbyte = mem_req_in.wdata[7:0];
      end else if (mem_req_in.addr == kes_pkg::KES_OUTBYTE_OFS) begin
        next_st.outbyte = mem_req_in.wdata[7:0];
      end else if (mem_req_in.addr == kes_pkg::KES_STATUS_OFS) begin
        next_st.status = mem_req_in.wdata[7:0]; // R2 R12 R19
      end
    end
    if (mem_req_in.rd) begin
      if (mem_req_in.addr == kes_pkg::KES_CONTROL_OFS) begin
        next_st.mem_rdata = {28'h0000000, st.control[3:2], emu_irq, st.control[0]};
      end else if (mem_req_in.addr == kes_pkg::KES_INBYTE_OFS) begin
        next_st.mem_rdata = {24'h000000, st.inbyte};
      end else if (mem_req_in.addr == kes_pkg::KES_OUTBYTE_OFS) begin
        next_st.mem_rdata = {24'h000000, st.outbyte};
      end else if (mem_req_in.addr == kes_pkg::KES_STATUS_OFS) begin
        next_st.mem_rdata = {24'h000000, st.status}; // R2
      end else begin
        next_st.mem_rdata = kes_pkg::KES_WORD_RST;
      end
    end
    // Port write path wins over a same-cycle software write
    if (io_hit && io_req_in.wr) begin
      next_st.inbyte = io_req_in.wdata; // R16
      next_st.status[kes_pkg::KES_ST_CMD_DATA] = io_cmd_port; // R3
      if (!a20_seq_in) begin
        next_st.status[kes_pkg::KES_ST_IN_FULL] = 1'b1; // R4
      end
    end
    // Error reports are sticky until software writes them back
    if (parity_err_in) begin
      next_st.status[kes_pkg::KES_ST_PARITY] = 1'b1; // R10
    end
    if (timeout_in) begin
      next_st.status[kes_pkg::KES_ST_TIMEOUT] = 1'b1; // R10
    end
    // Only a real switch movement overrides the stored bit
    if (inhibit_change) begin
      next_st.status[kes_pkg::KES_ST_INHIBIT] = inhibit_level; // R11
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st.status <= kes_pkg::KES_STATUS_RST; // R19
      st.control <= kes_pkg::KES_CONTROL_RST;
      st.inbyte <= kes_pkg::KES_BYTE_RST;
      st.outbyte <= kes_pkg::KES_BYTE_RST;
      st.io_rdata <= kes_pkg::KES_BYTE_RST;
      st.mem_rdata <= kes_pkg::KES_WORD_RST;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign mem_rdata_out = st.mem_rdata;
  assign io_rdata_out = st.io_rdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  logic mem_st_wr;
  logic hw_quiet;
  assign mem_st_wr = mem_req_in.wr && (mem_req_in.addr == kes_pkg::KES_STATUS_OFS);
  assign hw_quiet = !(io_hit && (io_req_in.wr || io_req_in.rd)) &&
    !parity_err_in && !timeout_in && !inhibit_change;

  sequence data_write_s;
    ce_in && io_hit && io_req_in.wr && io_data_port;
  endsequence

  sequence cmd_write_s;
    ce_in && io_hit && io_req_in.wr && io_cmd_port;
  endsequence

  sequence data_read_s;
    ce_in && io_hit && io_req_in.rd && io_data_port && !mem_st_wr;
  endsequence

  status_port_read_a: assert property (ce_in && io_hit && io_req_in.rd && io_cmd_port // R1
    |=> io_rdata_out == $past(st.status)) else $error("status port read data wrong");

  mem_no_effect_a: assert property (ce_in && !mem_st_wr && hw_quiet // R2
    |=> $stable(st.status)) else $error("status changed without cause");

  data_write_cd_a: assert property (data_write_s // R3 R16
    |=> !st.status[kes_pkg::KES_ST_CMD_DATA] && st.inbyte == $past(io_req_in.wdata))
    else $error("data port write not captured");

  cmd_write_cd_a: assert property (cmd_write_s // R3
    |=> st.status[kes_pkg::KES_ST_CMD_DATA]) else $error("command bit not set");

  input_full_set_a: assert property ((data_write_s or cmd_write_s) ##0 !a20_seq_in // R4
    |=> st.status[kes_pkg::KES_ST_IN_FULL] ##0 emu_irq_out) // R5
    else $error("input full or interrupt missing");

  out_full_clear_a: assert property (data_read_s // R6 R17
    |=> !st.status[kes_pkg::KES_ST_OUT_FULL] && io_rdata_out == $past(st.outbyte))
    else $error("data port read wrong");

  char_pend_irq_a: assert property (emulation_enable && !st.status[kes_pkg::KES_ST_OUT_FULL] // R7
    && st.control[kes_pkg::KES_CT_CHAR_PEND] |-> emu_irq_out)
    else $error("character pending interrupt missing");

  legacy_line_sel_a: assert property (emulation_enable && legacy_irq_enable // R8 R9 R15
    && st.status[kes_pkg::KES_ST_OUT_FULL]
    |-> (aux_device_irq_line_out == st.status[kes_pkg::KES_ST_AUX_FULL])
    && (keyboard_irq_line_out != aux_device_irq_line_out))
    else $error("legacy line selection wrong");

  // Either pulse alone must leave its own bit set at the next edge
  error_flags_a: assert property (ce_in && (parity_err_in || timeout_in) // R10
    |=> (st.status[kes_pkg::KES_ST_PARITY] || !$past(parity_err_in))
    && (st.status[kes_pkg::KES_ST_TIMEOUT] || !$past(timeout_in)))
    else $error("error flags not set");

  inhibit_follow_a: assert property (ce_in && inhibit_change // R11
    |=> st.status[kes_pkg::KES_ST_INHIBIT] == $past(inhibit_level))
    else $error("inhibit bit not updated");

  disabled_quiet_a: assert property (!emulation_enable |-> !io_claim_out // R14
    && !keyboard_irq_line_out && !aux_device_irq_line_out && !emu_irq_out)
    else $error("activity while emulation off");

  sw_write_a: assert property (ce_in && mem_st_wr && hw_quiet // R12 R19
    |=> st.status == $past(mem_req_in.wdata[7:0])) else $error("status write lost");

endmodule // kes_core

`default_nettype wire

// >>> verif/kes_legacy_sw.sv
// Model of legacy software reaching the keyboard data and command ports
`timescale 1ns/1ps
`default_nettype none

module kes_legacy_sw (
  input wire logic clk_in, // Register clock
  input wire logic [7:0] io_rdata_in, // Port read data
  input wire logic io_claim_in, // Port access decoded
  output var kes_pkg::kes_io_req_t io_req_out, // Port request
  output var logic a20_seq_out // Gate A20 qualifier
);
  // Idle until the first access
  initial begin
    io_req_out = '0;
    a20_seq_out = 1'h0;
  end

  // One port access: raised after an edge, held over the taking edge, then released.
  // Released lines show inverted data so a stale byte can never pass for a fresh one.
  task automatic io_acc(input logic rd, input logic [7:0] port, input logic [7:0] wdata,
                        input logic a20, output logic claim, output logic [7:0] rdata);
    @(posedge clk_in);
    io_req_out <= '{rd: rd, wr: !rd, port: port, wdata: wdata};
    a20_seq_out <= a20;
    #1 claim = io_claim_in;
    @(posedge clk_in);
    io_req_out <= '{rd: 1'h0, wr: 1'h0, port: ~port, wdata: ~wdata};
    a20_seq_out <= 1'h0;
    #1 rdata = io_rdata_in;
  endtask
endmodule // kes_legacy_sw
`default_nettype wire

// >>> verif/kes_core_tb_top.sv
// Testbench: emulation status flags through register and legacy port accesses
`timescale 1ns/1ps
`default_nettype none

module kes_core_tb_top;
  logic clk_in, reset_n_in, ce_in, a20_seq_in, parity_err_in, timeout_in, inhibit_sw_in;
  kes_pkg::kes_mem_req_t mem_req_in;
  kes_pkg::kes_io_req_t io_req_in;
  logic [31:0] mem_rdata_out;
  logic [7:0] io_rdata_out;
  logic io_claim_out, emu_irq_out, keyboard_irq_line_out, aux_device_irq_line_out;
  int n_fail;
  int check_count;
  logic cl;
  logic [7:0] rb;
  logic [31:0] rw;

  kes_core dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .mem_req_in(mem_req_in), .mem_rdata_out(mem_rdata_out), .io_req_in(io_req_in),
    .io_rdata_out(io_rdata_out), .io_claim_out(io_claim_out), .a20_seq_in(a20_seq_in),
    .parity_err_in(parity_err_in), .timeout_in(timeout_in), .inhibit_sw_in(inhibit_sw_in),
    .emu_irq_out(emu_irq_out), .keyboard_irq_line_out(keyboard_irq_line_out),
    .aux_device_irq_line_out(aux_device_irq_line_out));
  kes_legacy_sw sw_u (.clk_in(clk_in), .io_rdata_in(io_rdata_out),
    .io_claim_in(io_claim_out), .io_req_out(io_req_in), .a20_seq_out(a20_seq_in));

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Register access held over exactly one taking edge
  task automatic reg_acc(input logic rd, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge clk_in);
    mem_req_in <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
    @(posedge clk_in);
    mem_req_in <= '{rd: 1'h0, wr: 1'h0, addr: ~addr, wdata: ~wdata};
    #1 rw = mem_rdata_out;
  endtask
  task automatic wr(input logic [11:0] addr, input logic [7:0] data);
    reg_acc(1'h0, addr, {24'h000000, data});
  endtask
  task automatic st_is(input logic [7:0] exp, input string what);
    reg_acc(1'h1, kes_pkg::KES_STATUS_OFS, 32'h00000000);
    chk(rw, {24'h000000, exp}, what);
  endtask
  task automatic irqs(input logic [2:0] exp, input string what);
    chk({29'h0, emu_irq_out, keyboard_irq_line_out, aux_device_irq_line_out},
        {29'h0, exp}, what);
  endtask
  task automatic tdone(input string name);
    $display("Test %s done, mismatches so far %0d", name, n_fail);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Free-running 40 MHz clock
  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Hang guard, far beyond the roughly 130 cycles the tests need
  initial begin
    #(25 * 5000);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    n_fail = 0;
    check_count = 0;
    reset_n_in = 1'h0;
    ce_in = 1'h1;
    mem_req_in = '0;
    parity_err_in = 1'h0;
    timeout_in = 1'h0;
    inhibit_sw_in = 1'h0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'h1;
    st_is(8'h00, "status reset");
    reg_acc(1'h1, kes_pkg::KES_CONTROL_OFS, 32'h0);
    chk(rw, 32'h0, "control reset");
    irqs(3'h0, "lines after reset");
    tdone("reset");
    // Ports are dead while emulation is off
    sw_u.io_acc(1'h0, kes_pkg::KES_DATA_PORT, 8'h11, 1'h0, cl, rb);
    chk({31'h0, cl}, 32'h0, "claim with emulation off");
    st_is(8'h00, "status with emulation off");
    tdone("disabled");
    // Data port write: byte captured, input full, data marked
    wr(kes_pkg::KES_CONTROL_OFS, 8'h01);
    sw_u.io_acc(1'h0, kes_pkg::KES_DATA_PORT, 8'hAB, 1'h0, cl, rb);
    chk({31'h0, cl}, 32'h1, "claim data write");
    st_is(8'h02, "after data write");
    irqs(3'h4, "input full interrupt");
    reg_acc(1'h1, kes_pkg::KES_INBYTE_OFS, 32'h0);
    chk(rw, 32'h000000AB, "input byte");
    tdone("data write");
    // Command writes, with and without gate A20, then status through the command port
    wr(kes_pkg::KES_STATUS_OFS, 8'h00);
    sw_u.io_acc(1'h0, kes_pkg::KES_CMD_PORT, 8'hD1, 1'h1, cl, rb);
    st_is(8'h08, "gate A20 command");
    sw_u.io_acc(1'h0, kes_pkg::KES_CMD_PORT, 8'hCD, 1'h0, cl, rb);
    st_is(8'h0A, "plain command");
    sw_u.io_acc(1'h1, kes_pkg::KES_CMD_PORT, 8'h00, 1'h0, cl, rb);
    chk({24'h0, rb}, 32'h0000000A, "command port read");
    st_is(8'h0A, "status after reads");
    tdone("command");
    // Output full routed to keyboard or auxiliary line, cleared by data port read
    wr(kes_pkg::KES_CONTROL_OFS, 8'h09);
    wr(kes_pkg::KES_OUTBYTE_OFS, 8'h5A);
    wr(kes_pkg::KES_STATUS_OFS, 8'h01);
    irqs(3'h2, "keyboard line");
    wr(kes_pkg::KES_STATUS_OFS, 8'h21);
    irqs(3'h1, "auxiliary line");
    sw_u.io_acc(1'h1, kes_pkg::KES_DATA_PORT, 8'h00, 1'h0, cl, rb);
    chk({24'h0, rb}, 32'h0000005A, "data port read");
    st_is(8'h20, "output full cleared");
    irqs(3'h0, "lines after read");
    tdone("output");
    // Character pending raises the interrupt while output is empty
    wr(kes_pkg::KES_CONTROL_OFS, 8'h05);
    wr(kes_pkg::KES_STATUS_OFS, 8'h00);
    irqs(3'h4, "char pending interrupt");
    reg_acc(1'h1, kes_pkg::KES_CONTROL_OFS, 32'h0);
    chk(rw, 32'h00000007, "control live interrupt");
    wr(kes_pkg::KES_STATUS_OFS, 8'h01);
    irqs(3'h0, "output full stops pending");
    tdone("pending");
    // Enable off masks every line and port even with flags set
    wr(kes_pkg::KES_CONTROL_OFS, 8'h08);
    wr(kes_pkg::KES_STATUS_OFS, 8'h03);
    irqs(3'h0, "lines masked");
    sw_u.io_acc(1'h1, kes_pkg::KES_DATA_PORT, 8'h00, 1'h0, cl, rb);
    chk({31'h0, cl}, 32'h0, "claim masked");
    st_is(8'h03, "flags kept");
    tdone("masked");
    // Software flag, parity, time-out, inhibit switch and clock enable
    wr(kes_pkg::KES_STATUS_OFS, 8'h04);
    st_is(8'h04, "software flag");
    @(posedge clk_in) parity_err_in <= 1'h1;
    @(posedge clk_in) parity_err_in <= 1'h0;
    st_is(8'h84, "parity");
    @(posedge clk_in) timeout_in <= 1'h1;
    @(posedge clk_in) timeout_in <= 1'h0;
    st_is(8'hC4, "time-out");
    @(posedge clk_in) inhibit_sw_in <= 1'h1;
    repeat (10) @(posedge clk_in);
    st_is(8'hD4, "inhibit active");
    @(posedge clk_in) inhibit_sw_in <= 1'h0;
    repeat (10) @(posedge clk_in);
    st_is(8'hC4, "inhibit idle");
    @(posedge clk_in) ce_in <= 1'h0;
    wr(kes_pkg::KES_STATUS_OFS, 8'h00);
    @(posedge clk_in) ce_in <= 1'h1;
    st_is(8'hC4, "frozen write ignored");
    reg_acc(1'h1, 12'h200, 32'h0);
    chk(rw, 32'h0, "unmapped read");
    tdone("status bits");
    // Mid-run reset must drop every flag and control bit again
    @(posedge clk_in) reset_n_in <= 1'h0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'h1;
    st_is(8'h00, "status after mid-run reset");
    reg_acc(1'h1, kes_pkg::KES_CONTROL_OFS, 32'h0);
    chk(rw, 32'h0, "control after mid-run reset");
    irqs(3'h0, "lines after mid-run reset");
    tdone("mid reset");
    complete_run();
  end
endmodule // kes_core_tb_top
`default_nettype wire
